// file: adp_chk.sv
// Wire checks between host and converter ends
`timescale 1ns/1ps
`default_nettype none
module adp_chk
  import adp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        high_byte_select,
  input wire logic        busy_n,
  input wire logic [11:0] result_outputs,
  input wire logic        result_oe
);
  logic       gate;
  logic [9:0] low_r;
  logic [9:0] low_nxt;
  assign gate = !cs_n && !rd_n && !high_byte_select;
  always_comb low_nxt = busy_n ? 10'h000 : low_r + 10'h001;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) low_r <= 10'h000;
    else low_r <= low_nxt;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////
  chk_start_ack: assert property (
    gate && !$past(gate) && busy_n |=> !busy_n) else $error("start not acknowledged");
  chk_no_start: assert property (
    busy_n && !gate |=> busy_n) else $error("conversion began without start");
  chk_busy_len: assert property (
    $rose(busy_n) |-> low_r == CONV_CYCLES) else $error("conversion length wrong");
  chk_busy_max: assert property (
    !busy_n |-> low_r < CONV_CYCLES) else $error("conversion overran");
  chk_reset_idle: assert property (
    !$past(RST_N) |-> busy_n && !result_oe) else $error("not idle after reset");
  chk_oe_off: assert property (
    $past(cs_n || rd_n) |-> !result_oe) else $error("outputs driven unselected");
  chk_oe_on: assert property (
    $past(!cs_n && !rd_n) |-> result_oe) else $error("outputs not driven on read");
  chk_lane_mux: assert property (
    result_oe && $past(high_byte_select) |-> result_outputs[7:0] == {4'h0, result_outputs[11:8]})
    else $error("high byte lane wrong");
  chk_old_held: assert property (
    !busy_n && $past(!busy_n) && result_oe && $past(result_oe) |-> $stable(result_outputs[11:8]))
    else $error("data changed during conversion");
endmodule
`default_nettype wire

// file: adp_dev.sv
// Converter end: start gating, conversion timer, result latch, output lanes
//
// Overview of operation
// R01: Start only when all three selects low
// R02: Ignore starts while converting
// R03: Busy low during conversion, high otherwise
// R04: Internal timer ends conversion, no clock
// R05: Acquisition short enough for full throughput
// R06: Wait mode: busy low, old data shown
// R07: Latch new result, then busy high
// R08: Host waits out busy before capture
// R09: Result right justified in word
// R10: Byte select picks low or padded high
// R11: High byte read never starts conversion
// R12: Upper four outputs always carry MSBs
// R13: Wait two-byte: low starts, high reads
// R14: ROM read starts, returns old result
// R15: ROM reads spaced conversion plus gap
// R16: ROM second read after conversion time
// R17: ROM: high read no start, low restarts
// R18: Outputs released unless select and read low
`timescale 1ns/1ps
`default_nettype none
module adp_dev
  import adp_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  adp_if.dev               PINS,
  output logic [11:0]      RESULT_LATCH,
  output logic             CONV_DONE
);
  typedef enum logic {ADP_IDLE, ADP_CONV} adp_state_e;

  adp_state_e        state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [11:0]       res_r, res_nxt;
  logic [11:0]       sample_r, sample_nxt;
  logic              busy_n_r, busy_n_nxt;
  logic [11:0]       dout_r, dout_nxt;
  logic              oe_r, oe_nxt;
  logic              done_r, done_nxt;
  logic              sel_prev_r, sel_prev_nxt;
  logic              start_lvl;
  logic              sel;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    sel       = !PINS.cs_n && !PINS.rd_n;
    start_lvl = sel && !PINS.high_byte_select; // R01 R11
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    res_nxt      = res_r;
    sample_nxt   = sample_r;
    busy_n_nxt   = busy_n_r;
    done_nxt     = 1'b0;
    sel_prev_nxt = start_lvl;
    case (state_r)
      ADP_IDLE: begin
        // Edge of the gated start, so a held read does not retrigger
        if (start_lvl && !sel_prev_r) begin // R01 R06 R14
          state_nxt  = ADP_CONV;
          cnt_nxt    = '0;
          busy_n_nxt = 1'b0; // R03 R06
          sample_nxt = sample_r + SAMPLE_STEP;
        end
      end
      ADP_CONV: begin
        // Starts ignored here R02
        if (cnt_r == CNT_W'(CONV_CYCLES - 1)) begin // R04 R05
          state_nxt  = ADP_IDLE;
          res_nxt    = sample_r; // R07 R09
          busy_n_nxt = 1'b1; // R03 R07
          done_nxt   = 1'b1;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      default: state_nxt = ADP_IDLE;
    endcase
    // Latch and busy update on the same edge; dout from res_nxt shows the new word at the end R07 R13
    oe_nxt   = sel; // R18
    dout_nxt = {res_nxt[11:8], adp_lane(res_nxt, PINS.high_byte_select)}; // R10 R12 R17
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r    <= ADP_IDLE;
      cnt_r      <= '0;
      res_r      <= RESULT_RST;
      sample_r   <= SAMPLE_SEED;
      busy_n_r   <= 1'b1;
      dout_r     <= RESULT_RST;
      oe_r       <= 1'b0;
      done_r     <= 1'b0;
      sel_prev_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      res_r      <= res_nxt;
      sample_r   <= sample_nxt;
      busy_n_r   <= busy_n_nxt;
      dout_r     <= dout_nxt;
      oe_r       <= oe_nxt;
      done_r     <= done_nxt;
      sel_prev_r <= sel_prev_nxt;
    end
  end

  assign PINS.busy_n         = busy_n_r;
  assign PINS.result_outputs = dout_r;
  assign PINS.result_oe      = oe_r;
  assign RESULT_LATCH        = res_r;
  assign CONV_DONE           = done_r;
endmodule
`default_nettype wire

// file: adp_host.sv
// Host end: issues word or byte reads in wait or ROM mode
`timescale 1ns/1ps
`default_nettype none
module adp_host
  import adp_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_MAX_CYC,
  parameter int unsigned GAP_CYCLES  = ROM_GAP_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  adp_if.host              PINS,
  input  wire logic        REQ,
  input  wire logic        MODE_ROM,
  input  wire logic        TWO_BYTE,
  output logic             ACK,
  output logic [11:0]      DATA,
  output logic             BUSY
);
  typedef enum logic [2:0] {H_IDLE, H_RD1, H_SPACE, H_RD2, H_RD3, H_GAP} hst_state_e;

  hst_state_e        st_r, st_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              cs_n_r, cs_n_nxt, rd_n_r, rd_n_nxt, hb_r, hb_nxt;
  logic              ack_r, ack_nxt, rom_r, rom_nxt, two_r, two_nxt;
  logic [11:0]       data_r, data_nxt;
  logic              busy_r, busy_nxt;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r; cnt_nxt = cnt_r; cs_n_nxt = cs_n_r; rd_n_nxt = rd_n_r;
    hb_nxt = hb_r; ack_nxt = 1'b0; rom_nxt = rom_r; two_nxt = two_r; data_nxt = data_r;
    case (st_r)
      H_IDLE: if (REQ) begin
        rom_nxt = MODE_ROM; two_nxt = TWO_BYTE;
        cs_n_nxt = 1'b0; rd_n_nxt = 1'b0; hb_nxt = 1'b0;
        cnt_nxt = '0; st_nxt = H_RD1;
      end
      H_RD1: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        // Wait mode holds the read until busy returns high R08
        if (cnt_r > CNT_W'(1) && (rom_r || PINS.busy_n)) begin
          data_nxt = two_r ? {4'h0, PINS.result_outputs[7:0]} : PINS.result_outputs;
          cs_n_nxt = 1'b1; rd_n_nxt = 1'b1; cnt_nxt = '0;
          st_nxt = (two_r || rom_r) ? H_SPACE : H_GAP;
        end
      end
      H_SPACE: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        // ROM two-byte waits one conversion R16, ROM word adds the gap R15
        if (!rom_r || cnt_r >= (two_r ? CNT_W'(CONV_CYCLES) : CNT_W'(CONV_CYCLES + GAP_CYCLES))) begin
          cs_n_nxt = 1'b0; rd_n_nxt = 1'b0; hb_nxt = two_r; cnt_nxt = '0;
          st_nxt = H_RD2;
        end
      end
      H_RD2: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r > CNT_W'(1)) begin
          if (two_r) data_nxt = {PINS.result_outputs[3:0], data_r[7:0]};
          else data_nxt = PINS.result_outputs;
          cs_n_nxt = 1'b1; rd_n_nxt = 1'b1; hb_nxt = 1'b0; cnt_nxt = '0;
          st_nxt = (rom_r && two_r) ? H_RD3 : H_GAP;
        end
      end
      H_RD3: begin
        // Third read takes low byte and restarts R17
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r == CNT_W'(1)) begin
          cs_n_nxt = 1'b0; rd_n_nxt = 1'b0;
        end else if (cnt_r > CNT_W'(3)) begin
          data_nxt = {data_r[11:8], PINS.result_outputs[7:0]};
          cs_n_nxt = 1'b1; rd_n_nxt = 1'b1; cnt_nxt = '0; st_nxt = H_GAP;
        end
      end
      H_GAP: begin
        // Spacing covers conversion plus gap R15
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r >= CNT_W'(CONV_CYCLES + GAP_CYCLES)) begin
          ack_nxt = 1'b1; st_nxt = H_IDLE;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
    busy_nxt = (st_nxt != H_IDLE);
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= H_IDLE; cnt_r <= '0; cs_n_r <= 1'b1; rd_n_r <= 1'b1; hb_r <= 1'b0;
      ack_r <= 1'b0; rom_r <= 1'b0; two_r <= 1'b0; data_r <= RESULT_RST;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; cs_n_r <= cs_n_nxt; rd_n_r <= rd_n_nxt; hb_r <= hb_nxt;
      ack_r <= ack_nxt; rom_r <= rom_nxt; two_r <= two_nxt; data_r <= data_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign PINS.cs_n             = cs_n_r;
  assign PINS.rd_n             = rd_n_r;
  assign PINS.high_byte_select = hb_r;
  assign ACK                   = ack_r;
  assign DATA                  = data_r;
  assign BUSY                  = busy_r;
endmodule
`default_nettype wire

// file: adp_if.sv
// Pin bundle between host and converter port
`timescale 1ns/1ps
`default_nettype none
interface adp_if;
  logic        cs_n;
  logic        rd_n;
  logic        high_byte_select;
  logic        busy_n;
  logic [11:0] result_outputs;
  logic        result_oe;
  modport dev  (input cs_n, rd_n, high_byte_select, output busy_n, result_outputs, result_oe);
  modport host (output cs_n, rd_n, high_byte_select, input busy_n, result_outputs, result_oe);
endinterface
`default_nettype wire

// file: adp_pkg.sv
// Shared constants and types for the converter parallel read port
package adp_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned RESULT_W        = 12;
  localparam int unsigned LANE_W          = 8;
  localparam int unsigned HIGH_W          = 4;
  localparam int unsigned HIGH_LSB        = 8;
  localparam real         CONV_TYP_US     = 5.5;
  localparam real         CONV_MAX_US     = 6.0;
  localparam real         ACQ_MAX_US      = 1.14;
  localparam real         ROM_GAP_US      = 1.0;
  // Typical and longest times round down
  localparam int unsigned CONV_CYC        = int'($floor(CONV_TYP_US * CLK_HZ / 1.0e6));
  localparam int unsigned CONV_MAX_CYC    = int'($floor(CONV_MAX_US * CLK_HZ / 1.0e6));
  localparam int unsigned ACQ_CYC         = int'($floor(ACQ_MAX_US * CLK_HZ / 1.0e6));
  // Least time rounds up
  localparam int unsigned ROM_GAP_CYC     = int'($ceil(ROM_GAP_US * CLK_HZ / 1.0e6));
  localparam int unsigned CNT_W           = 10;
  localparam logic [11:0] RESULT_RST      = 12'h000;
  localparam logic [11:0] SAMPLE_SEED     = 12'h0A5;
  localparam logic [11:0] SAMPLE_STEP     = 12'h0123;
  localparam logic [3:0]  HIGH_PAD        = 4'h0;

  typedef enum logic {ADP_WAIT_MODE, ADP_ROM_MODE} adp_mode_e;

  function automatic logic [7:0] adp_lane(input logic [11:0] res, input logic hi);
    adp_lane = hi ? {HIGH_PAD, res[11:8]} : res[7:0];
  endfunction
endpackage

// file: testbench.sv
// Self-checking bench: host and converter ends back to back
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adp_pkg::*;
  localparam int CONV = 20;
  localparam logic [11:0] WORD1 = SAMPLE_SEED + SAMPLE_STEP;
  localparam logic [11:0] WORD2 = WORD1 + SAMPLE_STEP;
  logic [11:0] latch_d;
  logic        done;
  int          n_done;
  logic        clk;
  logic        rst_n;
  logic        req;
  logic        mode_rom;
  logic        two_byte;
  logic        ack;
  logic [11:0] data;
  logic        busy;
  logic [11:0] latch_m;
  int          n_conv;
  int          n_errors;
  int          comparisons;
  logic [1:0]  rows [5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b10};
  adp_if pins ();
  adp_if bad ();
  adp_dev #(.CONV_CYCLES(CONV)) adp_dev_i (.REF_CLK(clk), .RST_N(rst_n), .PINS(pins), .RESULT_LATCH(latch_d),
    .CONV_DONE(done));
  adp_dev #(.CONV_CYCLES(CONV)) adp_dev_i2 (.REF_CLK(clk), .RST_N(rst_n), .PINS(bad), .RESULT_LATCH(), .CONV_DONE());
  adp_host #(.CONV_CYCLES(CONV + 5)) adp_host_i (.REF_CLK(clk), .RST_N(rst_n), .PINS(pins), .REQ(req),
    .MODE_ROM(mode_rom), .TWO_BYTE(two_byte), .ACK(ack), .DATA(data), .BUSY(busy));
  adp_chk #(.CONV_CYCLES(CONV)) adp_chk_i (.REF_CLK(clk), .RST_N(rst_n), .cs_n(pins.cs_n), .rd_n(pins.rd_n),
    .high_byte_select(pins.high_byte_select), .busy_n(pins.busy_n), .result_outputs(pins.result_outputs),
    .result_oe(pins.result_oe));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic convert();
    n_conv++;
    latch_m = SAMPLE_SEED + SAMPLE_STEP * n_conv[11:0];
  endtask
  always @(posedge clk) if (done === 1'b1) n_done++;
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic host_read(input logic [1:0] row);
    logic [11:0] exp;
    int          k;
    convert();
    exp = latch_m;
    if (row[1] == 1'b1) convert();
    @(posedge clk);
    {mode_rom, two_byte, req} <= {row, 1'b1};
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (ack !== 1'b1 && k < 400);
    check("host ack", {11'h000, ack}, 12'h001);
    check("host idle", {11'h000, busy}, 12'h000);
    check("host data", data, exp);
    check("result latch", latch_d, latch_m);
    repeat (CONV + 10) @(posedge clk);
  endtask
  task automatic bad_pins(input logic [2:0] v, input int cyc);
    @(posedge clk);
    {bad.cs_n, bad.rd_n, bad.high_byte_select} <= v;
    repeat (cyc) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #(60000 * 20);
    n_errors++;
    end_sim();
  end
  initial begin
    {req, mode_rom, two_byte} = 3'b000;
    {bad.cs_n, bad.rd_n, bad.high_byte_select} = 3'b110;
    rst_n = 1'b0;
    n_conv = 0;
    latch_m = RESULT_RST;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) host_read(rows[i]);
    check("conversions", n_done[11:0], n_conv[11:0]);
    bad_pins(3'b001, 4);
    check("busy on high read", {11'h000, bad.busy_n}, 12'h001);
    check("oe on high read", {11'h000, bad.result_oe}, 12'h001);
    bad_pins(3'b000, CONV + 4);
    check("busy after held read", {11'h000, bad.busy_n}, 12'h001);
    check("word", bad.result_outputs, WORD1);
    bad_pins(3'b001, 2);
    check("high lane", bad.result_outputs, {WORD1[11:8], 4'h0, WORD1[11:8]});
    bad_pins(3'b111, 2);
    check("oe released", {11'h000, bad.result_oe}, 12'h000);
    bad_pins(3'b000, 3);
    bad_pins(3'b111, 2);
    bad_pins(3'b000, CONV - 3);
    check("busy no restart", {11'h000, bad.busy_n}, 12'h001);
    check("second word", bad.result_outputs, WORD2);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("busy in reset", {11'h000, bad.busy_n}, 12'h001);
    check("oe in reset", {11'h000, bad.result_oe}, 12'h000);
    end_sim();
  end
endmodule
`default_nettype wire
